// ---- src/smie_exec.sv ----
// Execution unit for a small subset of an 8-bit core's instructions.
// Assumes data memory answers a read in the same cycle in which o_mem_rd is high.
`timescale 1ns/1ps

// Summary of operation
// RQ1 - Right shift moves file bits toward bit 0 and fills bit 7 with zero.
// RQ2 - The bit shifted out of bit 0 goes into carry.
// RQ3 - Destination bit 0 writes accumulator, 1 writes the file register back.
// RQ4 - Indirect load reads memory at the chosen pointer into the accumulator.
// RQ5 - Codes 00 and 01 increment or decrement the pointer before addressing.
// RQ6 - Codes 10 and 11 address at the old pointer, then increment or decrement.
// RQ7 - Offset form adds a signed -32..31 offset; the pointer stays unchanged.
// RQ8 - Pointers are 16 bits and wrap at both ends.
// RQ9 - Bank literal loads a 5-bit literal into bank select.
// RQ10 - Page literal loads a 7-bit literal into the program counter upper latch.
// RQ11 - Accumulator literal loads an 8-bit literal into the accumulator.
// RQ12 - Store copies the accumulator to the directly addressed file register.
// RQ13 - Pointer updates never change the status flags.
// RQ14 - Shift and indirect load set zero from the result; others leave flags alone.
// RQ15 - Each instruction is one word and completes within one instruction cycle; here reads take one more cycle after accept, a shift back to the file two more.
module smie_exec
    import smie_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Instruction from the fetch stage.
    input wire logic i_instr_valid,
    input wire logic [13:0] i_instr,
    output logic o_instr_ready,
    output logic o_done,
    // Data memory port.
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    // Architectural state.
    output logic [7:0] o_acc,
    output logic o_carry,
    output logic o_zero,
    output logic [4:0] o_bank_select,
    output logic [6:0] o_program_counter_upper_latch,
    output logic [15:0] o_indirect_pointer0,
    output logic [15:0] o_indirect_pointer1
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and address arithmetic.

    function automatic smie_op_e decode_op(input logic [13:0] instr);
        smie_op_e op;
        op = SMIE_OP_NONE;
        if ((instr & SMIE_MASK_SHIFT) == SMIE_PAT_SHIFT) op = SMIE_OP_SHIFT;
        else if ((instr & SMIE_MASK_IND) == SMIE_PAT_IND) op = SMIE_OP_IND;
        else if ((instr & SMIE_MASK_REL) == SMIE_PAT_REL) op = SMIE_OP_REL;
        else if ((instr & SMIE_MASK_BANK) == SMIE_PAT_BANK) op = SMIE_OP_BANK;
        else if ((instr & SMIE_MASK_PAGE) == SMIE_PAT_PAGE) op = SMIE_OP_PAGE;
        else if ((instr & SMIE_MASK_ACC) == SMIE_PAT_ACC) op = SMIE_OP_ACC;
        else if ((instr & SMIE_MASK_STORE) == SMIE_PAT_STORE) op = SMIE_OP_STORE;
        return op;
    endfunction : decode_op

    // Low bit of the update code picks decrement; 16-bit width gives the wrap.
    function automatic logic [15:0] step_ptr(input logic [15:0] ptr, input logic [1:0] code);
        return code[0] ? ptr - 16'h0001 : ptr + 16'h0001; // RQ8
    endfunction : step_ptr

    smie_state_e state_q;
    smie_op_e op_q;
    logic dest_q;
    logic sel_q;
    logic ready_q;
    logic done_q;
    logic rd_q;
    logic wr_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] acc_q;
    logic carry_q;
    logic zero_q;
    logic [4:0] bank_q;
    logic [6:0] page_q;
    logic [15:0] ptr_q [2];

    smie_op_e dec_op;
    logic accept;
    logic dec_sel;
    logic [1:0] dec_code;
    logic [15:0] dec_ptr;
    logic [15:0] dec_step;
    logic [15:0] dec_rel;
    logic [15:0] dec_direct;
    logic [7:0] shift_res;

    assign dec_op = decode_op(i_instr);
    assign accept = ready_q && i_instr_valid;
    assign dec_code = i_instr[1:0];
    assign dec_sel = (dec_op == SMIE_OP_REL) ? i_instr[SMIE_SEL_BIT_REL]
                                             : i_instr[SMIE_SEL_BIT_IND];
    assign dec_ptr = ptr_q[dec_sel];
    assign dec_step = step_ptr(dec_ptr, dec_code);
    assign dec_rel = dec_ptr + {{10{i_instr[5]}}, i_instr[5:0]}; // RQ7
    assign dec_direct = {4'h0, bank_q, i_instr[6:0]};
    assign shift_res = {1'b0, i_mem_rdata[7:1]}; // RQ1

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing: literals and stores finish at accept, reads take one more cycle, a shift back to the file two more.

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_q <= SMIE_ST_IDLE;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            op_q <= SMIE_OP_NONE;
            dest_q <= 1'b0;
            sel_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            unique case (state_q)
                SMIE_ST_IDLE:
                begin
                    if (accept)
                    begin
                        op_q <= dec_op;
                        dest_q <= i_instr[SMIE_DEST_BIT];
                        sel_q <= dec_sel;
                        if (dec_op == SMIE_OP_SHIFT || dec_op == SMIE_OP_IND
                            || dec_op == SMIE_OP_REL)
                        begin
                            state_q <= SMIE_ST_READ;
                            ready_q <= 1'b0;
                        end
                        else
                        begin
                            done_q <= 1'b1; // RQ15
                        end
                    end
                end
                SMIE_ST_READ:
                begin
                    if (op_q == SMIE_OP_SHIFT && dest_q)
                    begin
                        state_q <= SMIE_ST_WRITE;
                    end
                    else
                    begin
                        state_q <= SMIE_ST_IDLE;
                        ready_q <= 1'b1;
                        done_q <= 1'b1; // RQ15
                    end
                end
                SMIE_ST_WRITE:
                begin
                    state_q <= SMIE_ST_IDLE;
                    ready_q <= 1'b1;
                    done_q <= 1'b1; // RQ15
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory port.

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end
        else
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            if (state_q == SMIE_ST_IDLE && accept)
            begin
                unique case (dec_op)
                    SMIE_OP_SHIFT:
                    begin
                        rd_q <= 1'b1;
                        addr_q <= dec_direct;
                    end
                    SMIE_OP_IND:
                    begin
                        rd_q <= 1'b1; // RQ4
                        addr_q <= dec_code[1] ? dec_ptr : dec_step; // RQ5 RQ6
                    end
                    SMIE_OP_REL:
                    begin
                        rd_q <= 1'b1;
                        addr_q <= dec_rel; // RQ7
                    end
                    SMIE_OP_STORE:
                    begin
                        wr_q <= 1'b1;
                        addr_q <= dec_direct; // RQ12
                        wdata_q <= acc_q; // RQ12
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (state_q == SMIE_ST_READ && op_q == SMIE_OP_SHIFT && dest_q)
            begin
                wr_q <= 1'b1; // RQ3
                wdata_q <= shift_res;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator and status flags.

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            acc_q <= SMIE_RST_ACC;
            carry_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else if (state_q == SMIE_ST_IDLE && accept && dec_op == SMIE_OP_ACC)
        begin
            acc_q <= i_instr[7:0]; // RQ11
        end
        else if (state_q == SMIE_ST_READ)
        begin
            if (op_q == SMIE_OP_SHIFT)
            begin
                carry_q <= i_mem_rdata[0]; // RQ2
                zero_q <= (shift_res == 8'h00); // RQ14
                if (!dest_q)
                begin
                    acc_q <= shift_res; // RQ3
                end
            end
            else
            begin
                acc_q <= i_mem_rdata; // RQ4
                zero_q <= (i_mem_rdata == 8'h00); // RQ14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bank select, page latch and indirect pointers.

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            bank_q <= SMIE_RST_BANK;
            page_q <= SMIE_RST_PAGE;
        end
        else if (state_q == SMIE_ST_IDLE && accept && dec_op == SMIE_OP_BANK)
        begin
            bank_q <= i_instr[4:0]; // RQ9
        end
        else if (state_q == SMIE_ST_IDLE && accept && dec_op == SMIE_OP_PAGE)
        begin
            page_q <= i_instr[6:0]; // RQ10
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            ptr_q[0] <= SMIE_RST_PTR;
            ptr_q[1] <= SMIE_RST_PTR;
        end
        else if (state_q == SMIE_ST_IDLE && accept && dec_op == SMIE_OP_IND)
        begin
            ptr_q[dec_sel] <= dec_step; // RQ5 RQ6 RQ8 RQ13
        end
    end

    assign o_instr_ready = ready_q;
    assign o_done = done_q;
    assign o_mem_rd = rd_q;
    assign o_mem_wr = wr_q;
    assign o_mem_addr = addr_q;
    assign o_mem_wdata = wdata_q;
    assign o_acc = acc_q;
    assign o_carry = carry_q;
    assign o_zero = zero_q;
    assign o_bank_select = bank_q;
    assign o_program_counter_upper_latch = page_q;
    assign o_indirect_pointer0 = ptr_q[0];
    assign o_indirect_pointer1 = ptr_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_shift_acc;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_q == SMIE_ST_READ && op_q == SMIE_OP_SHIFT && !dest_q)
            |=> (acc_q == {1'b0, $past(i_mem_rdata[7:1])});
    endproperty
    a_shift_acc: assert property (p_shift_acc) else $error("shift result wrong"); // RQ1

    property p_shift_carry;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_q == SMIE_ST_READ && op_q == SMIE_OP_SHIFT)
            |=> (carry_q == $past(i_mem_rdata[0]))
                && (zero_q == ($past(i_mem_rdata[7:1]) == 7'h00));
    endproperty
    a_shift_carry: assert property (p_shift_carry) else $error("shift flags wrong"); // RQ2

    property p_shift_file;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_q == SMIE_ST_READ && op_q == SMIE_OP_SHIFT && dest_q)
            |=> o_mem_wr && (o_mem_wdata == {1'b0, $past(i_mem_rdata[7:1])}) && $stable(acc_q)
                ##1 o_done && !o_mem_wr;
    endproperty
    a_shift_file: assert property (p_shift_file) else $error("shift write-back wrong"); // RQ3

    property p_ind_load;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && (dec_op == SMIE_OP_IND || dec_op == SMIE_OP_REL))
            |=> o_mem_rd ##1 (acc_q == $past(i_mem_rdata)) && o_done;
    endproperty
    a_ind_load: assert property (p_ind_load) else $error("indirect load wrong"); // RQ4

    property p_pre_mod;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && dec_op == SMIE_OP_IND && !dec_code[1])
            |=> (o_mem_addr == (sel_q ? o_indirect_pointer1 : o_indirect_pointer0))
                && (o_mem_addr == ($past(dec_code[0]) ? $past(dec_ptr) - 16'h0001
                                                      : $past(dec_ptr) + 16'h0001));
    endproperty
    a_pre_mod: assert property (p_pre_mod) else $error("pre-modify address wrong"); // RQ5

    property p_post_mod;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && dec_op == SMIE_OP_IND && dec_code[1])
            |=> (o_mem_addr == $past(dec_ptr))
                && ((sel_q ? o_indirect_pointer1 : o_indirect_pointer0) == $past(dec_step));
    endproperty
    a_post_mod: assert property (p_post_mod) else $error("post-modify wrong"); // RQ6

    property p_rel_keep;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && dec_op == SMIE_OP_REL)
            |=> $stable(o_indirect_pointer0) && $stable(o_indirect_pointer1)
                && (o_mem_addr == $past(dec_rel));
    endproperty
    a_rel_keep: assert property (p_rel_keep) else $error("offset form moved pointer"); // RQ7

    property p_flags_kept;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && dec_op != SMIE_OP_SHIFT && dec_op != SMIE_OP_IND && dec_op != SMIE_OP_REL)
            |=> $stable(carry_q) && $stable(zero_q);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed"); // RQ14

    // Carry must ride through both cycles of an indirect load untouched.
    property p_ptr_flags;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && (dec_op == SMIE_OP_IND || dec_op == SMIE_OP_REL))
            |=> $stable(carry_q) ##1 $stable(carry_q);
    endproperty
    a_ptr_flags: assert property (p_ptr_flags) else $error("pointer update changed carry"); // RQ13

    property p_literals;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && dec_op == SMIE_OP_BANK) |=> (o_bank_select == $past(i_instr[4:0])) && o_done;
    endproperty
    a_literals: assert property (p_literals) else $error("bank literal wrong"); // RQ9

    property p_store;
        @(posedge i_clk_sys) disable iff (i_rst)
        (accept && dec_op == SMIE_OP_STORE)
            |=> o_mem_wr && (o_mem_wdata == $past(acc_q)) && o_done && o_instr_ready;
    endproperty
    a_store: assert property (p_store) else $error("store wrong"); // RQ12

endmodule : smie_exec

// ---- shared/smie_pkg.sv ----
// Constants for the shift, indirect load and literal move execution block.
// Assumes a 14-bit instruction word and a 16-bit linear data memory address.
package smie_pkg;

    // Opcode patterns and the masks that select their fixed bits.
    localparam logic [13:0] SMIE_MASK_SHIFT = 14'h3F00;
    localparam logic [13:0] SMIE_PAT_SHIFT = 14'h3600;
    localparam logic [13:0] SMIE_MASK_IND = 14'h3FF8;
    localparam logic [13:0] SMIE_PAT_IND = 14'h0010;
    localparam logic [13:0] SMIE_MASK_REL = 14'h3F80;
    localparam logic [13:0] SMIE_PAT_REL = 14'h3F00;
    localparam logic [13:0] SMIE_MASK_BANK = 14'h3FE0;
    localparam logic [13:0] SMIE_PAT_BANK = 14'h0020;
    localparam logic [13:0] SMIE_MASK_PAGE = 14'h3F80;
    localparam logic [13:0] SMIE_PAT_PAGE = 14'h3180;
    localparam logic [13:0] SMIE_MASK_ACC = 14'h3F00;
    localparam logic [13:0] SMIE_PAT_ACC = 14'h3000;
    localparam logic [13:0] SMIE_MASK_STORE = 14'h3F80;
    localparam logic [13:0] SMIE_PAT_STORE = 14'h0080;

    // Field positions inside the instruction word.
    localparam int SMIE_DEST_BIT = 7;
    localparam int SMIE_SEL_BIT_IND = 2;
    localparam int SMIE_SEL_BIT_REL = 6;

    // Values after reset.
    localparam logic [7:0] SMIE_RST_ACC = 8'h00;
    localparam logic [4:0] SMIE_RST_BANK = 5'h00;
    localparam logic [6:0] SMIE_RST_PAGE = 7'h00;
    localparam logic [15:0] SMIE_RST_PTR = 16'h0000;

    typedef enum logic [2:0] {
        SMIE_OP_NONE,
        SMIE_OP_SHIFT,
        SMIE_OP_IND,
        SMIE_OP_REL,
        SMIE_OP_BANK,
        SMIE_OP_PAGE,
        SMIE_OP_ACC,
        SMIE_OP_STORE
    } smie_op_e;

    typedef enum logic [1:0] {
        SMIE_ST_IDLE,
        SMIE_ST_READ,
        SMIE_ST_WRITE
    } smie_state_e;

endpackage : smie_pkg

// ---- sim/smie_mem_model.sv ----
// Behavioural data memory that faces the execution block.
// Assumes reads are answered in the strobe cycle and writes land on the rising edge.
`timescale 1ns/1ps
module smie_mem_model
(
    // Clock.
    input wire logic i_clk_sys,
    // Memory port from the block.
    input wire logic i_mem_rd,
    input wire logic i_mem_wr,
    input wire logic [15:0] i_mem_addr,
    input wire logic [7:0] i_mem_wdata,
    output logic [7:0] o_mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] idle_q;

    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = a[7:0] ^ a[15:8] ^ 8'h3C;
        idle_q = 8'hA5;
    end

    // Outside a read the lines invert each cycle: the last answer inverted, then the last answer again.
    assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : idle_q;

    always @(posedge i_clk_sys)
    begin
        idle_q <= ~o_mem_rdata;
        if (i_mem_wr)
            mem[i_mem_addr] <= i_mem_wdata;
    end
endmodule : smie_mem_model

// ---- sim/shift_move_indirect_exec_bench.sv ----
// Self-checking bench for the shift, indirect load and literal move block.
// Assumes the memory model answers reads in the same cycle as the read strobe.
`timescale 1ns/1ps
module shift_move_indirect_exec_bench
    import smie_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic ready, done, mem_rd, mem_wr, carry, zero;
    logic [15:0] mem_addr, ptr0, ptr1;
    logic [7:0] mem_wdata, mem_rdata, acc;
    logic [4:0] bank;
    logic [6:0] page;
    logic [7:0] e_acc;
    logic [7:0] e_mem [0:65535];
    logic e_c, e_z;
    logic [4:0] e_bank;
    logic [6:0] e_page;
    logic [15:0] e_p [2];
    int bad_count = 0;
    int n_compared = 0;
    localparam logic [13:0] K_MASK [7] = '{SMIE_MASK_SHIFT, SMIE_MASK_IND, SMIE_MASK_REL,
        SMIE_MASK_BANK, SMIE_MASK_PAGE, SMIE_MASK_ACC, SMIE_MASK_STORE};
    localparam logic [13:0] K_PAT [7] = '{SMIE_PAT_SHIFT, SMIE_PAT_IND, SMIE_PAT_REL,
        SMIE_PAT_BANK, SMIE_PAT_PAGE, SMIE_PAT_ACC, SMIE_PAT_STORE};

    always #50 clk = ~clk;

    smie_exec i_smie_exec (.i_clk_sys(clk), .i_rst(rst), .i_instr_valid(valid),
        .i_instr(instr), .o_instr_ready(ready), .o_done(done), .o_mem_rd(mem_rd),
        .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_rdata(mem_rdata), .o_acc(acc), .o_carry(carry), .o_zero(zero),
        .o_bank_select(bank), .o_program_counter_upper_latch(page),
        .o_indirect_pointer0(ptr0), .o_indirect_pointer1(ptr1));

    smie_mem_model i_smie_mem_model (.i_clk_sys(clk), .i_mem_rd(mem_rd), .i_mem_wr(mem_wr),
        .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk_state();
        chk(16'(acc), 16'(e_acc));
        chk(16'(carry), 16'(e_c));
        chk(16'(zero), 16'(e_z));
        chk(16'(bank), 16'(e_bank));
        chk(16'(page), 16'(e_page));
        chk(ptr0, e_p[0]);
        chk(ptr1, e_p[1]);
    endtask : chk_state

    // Works out the effect of one word on the expected state and the memory port.
    function automatic int predict(input logic [13:0] ins, output logic x_rd,
        output logic x_wr, output logic [15:0] x_addr, output logic [7:0] x_wdata);
        logic [15:0] p;
        logic [7:0] r;
        x_rd = 1'b0;
        x_wr = 1'b0;
        x_addr = {4'h0, e_bank, ins[6:0]};
        x_wdata = e_acc;
        if ((ins & SMIE_MASK_SHIFT) == SMIE_PAT_SHIFT)
        begin
            r = {1'b0, e_mem[x_addr][7:1]};
            x_rd = 1'b1;
            e_c = e_mem[x_addr][0];
            e_z = (r == 8'h00);
            x_wr = ins[7];
            x_wdata = r;
            if (ins[7])
                e_mem[x_addr] = r;
            else
                e_acc = r;
            return ins[7] ? 2 : 1;
        end
        if ((ins & SMIE_MASK_IND) == SMIE_PAT_IND || (ins & SMIE_MASK_REL) == SMIE_PAT_REL)
        begin
            x_rd = 1'b1;
            if (ins[13])
                x_addr = e_p[ins[6]] + {{10{ins[5]}}, ins[5:0]};
            else
            begin
                p = e_p[ins[2]];
                e_p[ins[2]] = ins[0] ? p - 16'h0001 : p + 16'h0001;
                x_addr = ins[1] ? p : e_p[ins[2]];
            end
            e_acc = e_mem[x_addr];
            e_z = (e_acc == 8'h00);
            return 1;
        end
        if ((ins & SMIE_MASK_BANK) == SMIE_PAT_BANK)
            e_bank = ins[4:0];
        else if ((ins & SMIE_MASK_PAGE) == SMIE_PAT_PAGE)
            e_page = ins[6:0];
        else if ((ins & SMIE_MASK_ACC) == SMIE_PAT_ACC)
            e_acc = ins[7:0];
        else if ((ins & SMIE_MASK_STORE) == SMIE_PAT_STORE)
        begin
            x_wr = 1'b1;
            e_mem[x_addr] = e_acc;
        end
        return 0;
    endfunction : predict

    // Presents one word, holds it until taken, then follows it to its done pulse.
    task automatic run(input logic [13:0] ins);
        logic x_rd, x_wr;
        logic [15:0] x_addr;
        logic [7:0] x_wdata;
        int lat, t, n_rd, n_wr;
        lat = predict(ins, x_rd, x_wr, x_addr, x_wdata);
        n_rd = 0;
        n_wr = 0;
        instr = ins;
        valid = 1'b1;
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (ready !== 1'b1 && t < 8);
        chk(16'(ready), 16'h0001);
        #1;
        valid = 1'b0;
        instr = 14'($urandom);
        for (t = 0; t < 6; t++)
        begin
            if (mem_rd === 1'b1)
            begin
                n_rd++;
                chk(mem_addr, x_addr);
            end
            if (mem_wr === 1'b1)
            begin
                n_wr++;
                chk(mem_addr, x_addr);
                chk(16'(mem_wdata), 16'(x_wdata));
            end
            chk(16'(ready), 16'(done));
            if (done === 1'b1)
                break;
            @(posedge clk);
            #1;
        end
        chk(16'(t), 16'(lat));
        chk(16'(n_rd), 16'(x_rd));
        chk(16'(n_wr), 16'(x_wr));
        chk_state();
        // Valid was lowered in this very time step; let an edge pass before the next word.
        if (t == 0)
        begin
            @(posedge clk);
            #1;
        end
    endtask : run

    task automatic do_reset(input int n);
        rst = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        rst = 1'b0;
        e_acc = SMIE_RST_ACC;
        e_c = 1'b0;
        e_z = 1'b0;
        e_bank = SMIE_RST_BANK;
        e_page = SMIE_RST_PAGE;
        e_p = '{SMIE_RST_PTR, SMIE_RST_PTR};
        chk_state();
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(100 * 20000);
        bad_count++;
        close_out();
    end

    initial
    begin
        for (int a = 0; a < 65536; a++)
            e_mem[a] = a[7:0] ^ a[15:8] ^ 8'h3C;
        void'($urandom(76));
        do_reset(6);
        $display("test reset finished");
        foreach (K_PAT[k])
            run(K_PAT[k] | ~K_MASK[k]);
        foreach (K_PAT[k])
            run(K_PAT[k]);
        run(14'h0000);
        $display("test literal bounds finished");
        run(14'h3081);
        run(14'h0023);
        run(14'h00FF);
        run(14'h36FF);
        run(14'h367F);
        run(14'h3001);
        run(14'h0885);
        run(14'h36C5);
        $display("test shift finished");
        for (int n = 0; n < 2; n++)
        begin
            for (int m = 3; m >= 0; m--)
                run(SMIE_PAT_IND | 14'(n * 4 + m));
            run(SMIE_PAT_REL | 14'(n * 64 + 32));
            run(SMIE_PAT_REL | 14'(n * 64 + 31));
        end
        $display("test indirect finished");
        repeat (300)
        begin
            int k;
            k = $urandom_range(0, 6);
            run(K_PAT[k] | (14'($urandom) & ~K_MASK[k]));
        end
        $display("test random finished");
        do_reset(2);
        repeat (100)
            run(14'($urandom));
        $display("test second reset finished");
        close_out();
    end
endmodule : shift_move_indirect_exec_bench
